/* File: common/hcp_pkg.sv */
`default_nettype none
package hcp_pkg;
  // Word offsets of the control and status block (byte addresses).
  localparam logic [3:0] CSR_FIRST_OFF = 4'h0;
  localparam logic [3:0] CSR_ADDR_OFF = 4'h4;
  localparam logic [3:0] CSR_DATA_OFF = 4'h6;
  localparam int CSR_WORDS = 8;
  // Bit positions inside the command byte (word bits).
  localparam int CMD_ERROR_BIT = 8;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_MODE_LO = 11;
  localparam int CMD_WRITE_BIT = 13;
  localparam int CMD_MASTER_CLEAR_REQUEST_BIT = 14;
  localparam int CMD_RUN_BIT = 15;
  // Mode field encodings.
  localparam logic [1:0] MODE_APP = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_MAINT1 = 2'h2;
  localparam logic [1:0] MODE_MAINT2 = 2'h3;
  // Application RAM: 32K bytes, 16K words.
  localparam int RAM_BYTES = 32768;
  localparam int RAM_WORD_AW = 14;
  // Reset values.
  localparam logic [15:0] CSR_RESET = 16'h0000;
  // Cycles spent clearing hardware during master clear.
  localparam int INIT_CYCLES = 16;
  // Cycles of built-in self-test pass.
  localparam int TEST_CYCLES = 32;
  // Controller states.
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_INIT = 3'b001,
    ST_TEST = 3'b010,
    ST_RDWAIT = 3'b011,
    ST_APPRUN = 3'b100,
    ST_PARK = 3'b101
  } hcp_state_t;
endpackage : hcp_pkg
`default_nettype wire

/* File: hw/hcp_ctrl.sv */
// What this block does
// - Eight CSR words, byte or word access.
// - Error flag on illegal RAM address.
// - Error flag on illegal run address.
// - Read bit fetches RAM into data word.
// - Bits 12:11 decode as mode field.
// - Application mode picks read or write.
// - Mode 2 runs built-in test.
// - Mode 3 clears master clear, parks.
// - Mode cleared on power-up and master clear.
// - Write bit stores data word into RAM.
// - Master clear without run reinitialises, then parks if mode 3 was asked, else idles.
// - Master clear bit self-clears when done.
// - Run bit starts application at address.
// - Run with master clear runs self-test first.
// - Stop instruction returns to root control.
// - 32K byte RAM bounds all address checks.
`default_nettype none
module hcp_ctrl #(
  parameter int RAM_BYTES = hcp_pkg::RAM_BYTES,
  parameter int INIT_CYCLES = hcp_pkg::INIT_CYCLES,
  parameter int TEST_CYCLES = hcp_pkg::TEST_CYCLES
) (
  // Clock and reset.
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // Host register port, synchronous to MCLK_IN.
  input wire logic [3:0] CSR_ADDR_IN,
  input wire logic CSR_WR_IN,
  input wire logic CSR_RD_IN,
  input wire logic [1:0] CSR_BE_IN,
  input wire logic [15:0] CSR_WDATA_IN,
  output logic [15:0] CSR_RDATA_OUT,
  // Processor side status.
  input wire logic HALT_IN,
  output logic APP_RUN_OUT,
  output logic [15:0] APP_START_OUT,
  output logic SELF_TEST_OUT
);
  ////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [15:0] csr_reg [0:hcp_pkg::CSR_WORDS-1];
  logic [15:0] csr_next [0:hcp_pkg::CSR_WORDS-1];
  hcp_pkg::hcp_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic run_after_reg, run_after_next;
  // Mode asked for with a master clear; the field itself is cleared at once, so it must be kept here.
  logic [1:0] req_mode_reg, req_mode_next;
  logic [15:0] start_reg, start_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [2:0] widx;
  logic [15:0] cmd;
  logic [15:0] ram_q;
  logic [1:0] ram_we;
  logic [hcp_pkg::RAM_WORD_AW-1:0] ram_a;
  logic addr_ok;
  logic [1:0] mode;

  assign widx = CSR_ADDR_IN[3:1];
  assign cmd = csr_reg[hcp_pkg::CSR_FIRST_OFF[3:1]];
  assign mode = cmd[hcp_pkg::CMD_MODE_LO +: 2];
  // Address must be a byte address inside the RAM space.
  assign addr_ok = 32'(csr_reg[hcp_pkg::CSR_ADDR_OFF[3:1]]) < RAM_BYTES;
  assign ram_a = csr_reg[hcp_pkg::CSR_ADDR_OFF[3:1]][hcp_pkg::RAM_WORD_AW:1];

  hcp_ram #(
    .AW(hcp_pkg::RAM_WORD_AW)
  ) u_ram (
    .clk_in(MCLK_IN),
    .addr_in(ram_a),
    .we_in(ram_we),
    .wdata_in(csr_reg[hcp_pkg::CSR_DATA_OFF[3:1]]),
    .rdata_out(ram_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command interpreter and CSR next values.
  always_comb
  begin
    for (int i = 0; i < hcp_pkg::CSR_WORDS; i++)
    begin
      csr_next[i] = csr_reg[i];
    end
    state_next = state_reg;
    cnt_next = cnt_reg;
    run_after_next = run_after_reg;
    req_mode_next = req_mode_reg;
    start_next = start_reg;
    ram_we = 2'b00;
    // Host byte or word writes; the firmware update below wins same cycle.
    if (CSR_WR_IN)
    begin
      if (CSR_BE_IN[0])
      begin
        csr_next[widx][7:0] = CSR_WDATA_IN[7:0];
      end
      if (CSR_BE_IN[1])
      begin
        csr_next[widx][15:8] = CSR_WDATA_IN[15:8];
      end
    end
    case (state_reg)
      hcp_pkg::ST_IDLE:
      begin
        if (cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT])
        begin
          // Clear mode field now (error at end of init), remember a pending run.
          run_after_next = cmd[hcp_pkg::CMD_RUN_BIT];
          req_mode_next = mode;
          csr_next[0][hcp_pkg::CMD_MODE_LO +: 2] = hcp_pkg::MODE_APP;
          cnt_next = 8'(INIT_CYCLES - 1);
          state_next = hcp_pkg::ST_INIT;
        end
        else if (mode == hcp_pkg::MODE_MAINT1)
        begin
          cnt_next = 8'(TEST_CYCLES - 1);
          state_next = hcp_pkg::ST_TEST;
        end
        else if (mode == hcp_pkg::MODE_APP)
        begin
          // Run takes priority, then write, then read.
          if (cmd[hcp_pkg::CMD_RUN_BIT])
          begin
            csr_next[0][hcp_pkg::CMD_RUN_BIT] = 1'b0;
            if (addr_ok)
            begin
              start_next = csr_reg[hcp_pkg::CSR_ADDR_OFF[3:1]];
              state_next = hcp_pkg::ST_APPRUN;
            end
            else
            begin
              csr_next[0][hcp_pkg::CMD_ERROR_BIT] = 1'b1;
            end
          end
          else if (cmd[hcp_pkg::CMD_WRITE_BIT])
          begin
            csr_next[0][hcp_pkg::CMD_WRITE_BIT] = 1'b0;
            if (addr_ok)
            begin
              ram_we = 2'b11;
            end
            else
            begin
              csr_next[0][hcp_pkg::CMD_ERROR_BIT] = 1'b1;
            end
          end
          else if (cmd[hcp_pkg::CMD_READ_BIT])
          begin
            if (addr_ok)
            begin
              state_next = hcp_pkg::ST_RDWAIT;
            end
            else
            begin
              csr_next[0][hcp_pkg::CMD_READ_BIT] = 1'b0;
              csr_next[0][hcp_pkg::CMD_ERROR_BIT] = 1'b1;
            end
          end
        end
      end
      hcp_pkg::ST_RDWAIT:
      begin
        // RAM data is registered; land it in the data word now.
        csr_next[hcp_pkg::CSR_DATA_OFF[3:1]] = ram_q;
        csr_next[0][hcp_pkg::CMD_READ_BIT] = 1'b0;
        state_next = hcp_pkg::ST_IDLE;
      end
      hcp_pkg::ST_INIT:
      begin
        if (cnt_reg == 8'h00)
        begin
          csr_next[0][hcp_pkg::CMD_ERROR_BIT] = 1'b0;
          if (run_after_reg)
          begin
            cnt_next = 8'(TEST_CYCLES - 1);
            state_next = hcp_pkg::ST_TEST;
          end
          else
          begin
            csr_next[0][hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT] = 1'b0;
            state_next = (req_mode_reg == hcp_pkg::MODE_MAINT2) ? hcp_pkg::ST_PARK : hcp_pkg::ST_IDLE;
          end
        end
        else
        begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      hcp_pkg::ST_TEST:
      begin
        if (cnt_reg == 8'h00)
        begin
          // After self-test a combined request completes and runs, or flags an error if the address is illegal.
          csr_next[0][hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT] = 1'b0;
          csr_next[0][hcp_pkg::CMD_RUN_BIT] = 1'b0;
          run_after_next = 1'b0;
          if (run_after_reg && addr_ok)
          begin
            start_next = csr_reg[hcp_pkg::CSR_ADDR_OFF[3:1]];
            state_next = hcp_pkg::ST_APPRUN;
          end
          else
          begin
            if (run_after_reg)
            begin
              csr_next[0][hcp_pkg::CMD_ERROR_BIT] = 1'b1;
            end
            csr_next[0][hcp_pkg::CMD_MODE_LO +: 2] = hcp_pkg::MODE_APP;
            state_next = hcp_pkg::ST_IDLE;
          end
        end
        else
        begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      hcp_pkg::ST_APPRUN:
      begin
        // A stop instruction hands control back to the root.
        if (HALT_IN)
        begin
          state_next = hcp_pkg::ST_IDLE;
        end
        else if (cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT])
        begin
          state_next = hcp_pkg::ST_IDLE;
        end
      end
      hcp_pkg::ST_PARK:
      begin
        // Continuous loop; only a fresh master clear leaves it.
        if (cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT])
        begin
          state_next = hcp_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = hcp_pkg::ST_IDLE;
      end
    endcase
  end

  // Read data for the host is registered one cycle after the strobe.
  always_comb
  begin
    rdata_next = rdata_reg;
    if (CSR_RD_IN)
    begin
      rdata_next = csr_reg[widx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < hcp_pkg::CSR_WORDS; i++)
      begin
        csr_reg[i] <= hcp_pkg::CSR_RESET;
      end
      state_reg <= hcp_pkg::ST_IDLE;
      cnt_reg <= 8'h00;
      run_after_reg <= 1'b0;
      req_mode_reg <= hcp_pkg::MODE_APP;
      start_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < hcp_pkg::CSR_WORDS; i++)
      begin
        csr_reg[i] <= csr_next[i];
      end
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      run_after_reg <= run_after_next;
      req_mode_reg <= req_mode_next;
      start_reg <= start_next;
      rdata_reg <= rdata_next;
    end
  end

  assign CSR_RDATA_OUT = rdata_reg;
  assign APP_RUN_OUT = (state_reg == hcp_pkg::ST_APPRUN);
  assign APP_START_OUT = start_reg;
  assign SELF_TEST_OUT = (state_reg == hcp_pkg::ST_TEST);

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  master_clear_request_done_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == hcp_pkg::ST_INIT && cnt_reg == 8'h00 && !run_after_reg) |=> !cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT])
    else $error("master clear bit not cleared");
  mode_clear_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == hcp_pkg::ST_IDLE && cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT] && !CSR_WR_IN) |=> mode == hcp_pkg::MODE_APP)
    else $error("mode not cleared by master clear");
  bad_write_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == hcp_pkg::ST_IDLE && mode == hcp_pkg::MODE_APP && !cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT]
     && !cmd[hcp_pkg::CMD_RUN_BIT] && cmd[hcp_pkg::CMD_WRITE_BIT] && !addr_ok) |=> cmd[hcp_pkg::CMD_ERROR_BIT])
    else $error("illegal write address not flagged");
  read_land_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == hcp_pkg::ST_RDWAIT) |=> (csr_reg[3] == $past(ram_q) && !cmd[hcp_pkg::CMD_READ_BIT]))
    else $error("read data not returned");
  run_start_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    APP_RUN_OUT |-> 32'(APP_START_OUT) < RAM_BYTES)
    else $error("run started at illegal address");
  halt_back_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (APP_RUN_OUT && HALT_IN) |=> !APP_RUN_OUT)
    else $error("halt did not return control");
  test_len_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    $rose(SELF_TEST_OUT) |-> SELF_TEST_OUT [*8])
    else $error("self-test cut short");
  init_path_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == hcp_pkg::ST_IDLE && cmd[hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT]) |=> state_reg == hcp_pkg::ST_INIT)
    else $error("master clear not started");
  run_cov_c: cover property (@(posedge MCLK_IN) $rose(APP_RUN_OUT));
  test_cov_c: cover property (@(posedge MCLK_IN) $rose(SELF_TEST_OUT));
  park_cov_c: cover property (@(posedge MCLK_IN) state_reg == hcp_pkg::ST_PARK);
endmodule : hcp_ctrl
`default_nettype wire

/* File: hw/hcp_ram.sv */
`default_nettype none
// Word RAM with byte write enables and registered read data.
module hcp_ram #(
  parameter int AW = 14
) (
  // Clock.
  input wire logic clk_in,
  // Access.
  input wire logic [AW-1:0] addr_in,
  input wire logic [1:0] we_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:(1<<AW)-1];

  // Byte lanes write separately so a byte-wide load keeps its neighbour.
  always_ff @(posedge clk_in)
  begin
    if (we_in[0])
    begin
      mem[addr_in][7:0] <= wdata_in[7:0];
    end
    if (we_in[1])
    begin
      mem[addr_in][15:8] <= wdata_in[15:8];
    end
    rdata_out <= mem[addr_in];
  end
endmodule : hcp_ram
`default_nettype wire

/* File: verification/hcp_host_model.sv */
`default_nettype none
// Host model: one register access at a time, strobes moved only just after rising edges.
module hcp_host_model
(
  // Clock.
  input wire logic clk_in,
  // Register port.
  output logic [3:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [1:0] be_out,
  output logic [15:0] wdata_out,
  input wire logic [15:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // The bus is idle at time zero.
  initial
  begin
    addr_out = 4'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    be_out = 2'h0;
    wdata_out = 16'h0000;
  end
  ////////////////////////////////////////
  // Write strobe lasts one cycle; released data is inverted so stale values never look valid.
  task automatic wr_word(input logic [3:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    be_out <= b;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : wr_word
  // Read data is registered, so it is taken one edge after the strobe is accepted.
  task automatic rd_word(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask : rd_word
  // No new command until every command bit has dropped; the count keeps a hang finite.
  task automatic wait_idle(output logic [15:0] w);
    int n;
    n = 0;
    rd_word(hcp_pkg::CSR_FIRST_OFF, w);
    while ((w & 16'he400) !== 16'h0000 && n < 200)
    begin
      rd_word(hcp_pkg::CSR_FIRST_OFF, w);
      n++;
    end
  endtask : wait_idle
endmodule : hcp_host_model
`default_nettype wire

/* File: verification/host_csr_firmware_command_port_tb.sv */
`default_nettype none
// Bench: the host model drives the port, a RAM model predicts the data read back from RAM.
module host_csr_firmware_command_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] C_ERR = 16'h0001 << hcp_pkg::CMD_ERROR_BIT;
  localparam logic [15:0] C_RD = 16'h0001 << hcp_pkg::CMD_READ_BIT;
  localparam logic [15:0] C_WR = 16'h0001 << hcp_pkg::CMD_WRITE_BIT;
  localparam logic [15:0] C_MC = 16'h0001 << hcp_pkg::CMD_MASTER_CLEAR_REQUEST_BIT;
  localparam logic [15:0] C_RUN = 16'h0001 << hcp_pkg::CMD_RUN_BIT;
  logic mclk;
  logic rst;
  logic halt;
  logic [3:0] addr;
  logic wr;
  logic rd;
  logic [1:0] be;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic app_run;
  logic [15:0] app_start;
  logic self_test;
  logic st_seen;
  logic [15:0] w;
  logic [15:0] mem [int];
  int aq [$];
  int a;
  int n_errors;
  int cmp_count;
  int cyc;
  ////////////////////////////////////////
  hcp_ctrl hcp_ctrl_inst (.MCLK_IN(mclk), .RST_IN(rst), .CSR_ADDR_IN(addr), .CSR_WR_IN(wr),
    .CSR_RD_IN(rd), .CSR_BE_IN(be), .CSR_WDATA_IN(wdata), .CSR_RDATA_OUT(rdata), .HALT_IN(halt),
    .APP_RUN_OUT(app_run), .APP_START_OUT(app_start), .SELF_TEST_OUT(self_test));
  hcp_host_model hcp_host_model_inst (.clk_in(mclk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .be_out(be), .wdata_out(wdata), .rdata_in(rdata));
  ////////////////////////////////////////
  // Clock, self-test monitor and hang guard.
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (self_test === 1'b1)
      st_seen <= 1'b1;
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  // Compare, count and report.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t %s", $time, m);
      n_errors++;
    end
  endtask : chk
  task automatic cmd(input logic [15:0] c);
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_FIRST_OFF, 2'b10, c);
    hcp_host_model_inst.wait_idle(w);
  endtask : cmd
  task automatic wr_addr(input int v);
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_ADDR_OFF, 2'b11, 16'(v));
  endtask : wr_addr
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  // Main sequence.
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    halt = 1'b0;
    st_seen = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    a = $urandom(56);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < hcp_pkg::CSR_WORDS; i++)
    begin
      hcp_host_model_inst.rd_word(4'(2 * i), w);
      chk(w, hcp_pkg::CSR_RESET, "reset value");
    end
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_ADDR_OFF, 2'b11, 16'h1234);
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_ADDR_OFF, 2'b01, 16'hffcd);
    hcp_host_model_inst.rd_word(hcp_pkg::CSR_ADDR_OFF, w);
    chk(w, 16'h12cd, "byte lanes");
    // Random words plus the top word of the space, read back newest first.
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? hcp_pkg::RAM_BYTES - 2 : ($urandom % hcp_pkg::RAM_BYTES) & ~1;
      aq.push_front(a);
      mem[a] = 16'($urandom);
      wr_addr(a);
      hcp_host_model_inst.wr_word(hcp_pkg::CSR_DATA_OFF, 2'b11, mem[a]);
      cmd(C_WR);
      chk(w, 16'h0000, "write status");
    end
    foreach (aq[i])
    begin
      wr_addr(aq[i]);
      cmd(C_RD);
      chk(w, 16'h0000, "read status");
      hcp_host_model_inst.rd_word(hcp_pkg::CSR_DATA_OFF, w);
      chk(w, mem[aq[i]], "read data");
    end
    // One byte past the space; each command write also clears the old error.
    wr_addr(hcp_pkg::RAM_BYTES);
    cmd(C_WR);
    chk(w, C_ERR, "write error");
    cmd(C_RD);
    chk(w, C_ERR, "read error");
    cmd(C_MC);
    chk(w, 16'h0000, "clear done");
    cmd(C_RUN);
    chk(w, C_ERR, "run error");
    chk({15'h0000, app_run}, 16'h0000, "no run");
    // Firmware was loaded above; start it at the newest word.
    wr_addr(aq[0]);
    cmd(C_RUN);
    chk(w, 16'h0000, "run status");
    chk({15'h0000, app_run}, 16'h0001, "running");
    chk(app_start, 16'(aq[0]), "start address");
    @(posedge mclk);
    halt <= 1'b1;
    @(posedge mclk);
    halt <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({15'h0000, app_run}, 16'h0000, "halted");
    // Reserved mode stays put; mode 2 runs one test pass then drops to mode 0.
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_FIRST_OFF, 2'b10, {3'h0, hcp_pkg::MODE_RSVD, 11'h000});
    hcp_host_model_inst.rd_word(hcp_pkg::CSR_FIRST_OFF, w);
    chk(w, 16'h0800, "reserved mode");
    st_seen <= 1'b0;
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_FIRST_OFF, 2'b10, {3'h0, hcp_pkg::MODE_MAINT1, 11'h000});
    repeat (2 * hcp_pkg::TEST_CYCLES) @(posedge mclk);
    hcp_host_model_inst.rd_word(hcp_pkg::CSR_FIRST_OFF, w);
    chk(w, 16'h0000, "test mode ends");
    chk({15'h0000, st_seen}, 16'h0001, "test ran");
    cmd(C_MC | {3'h0, hcp_pkg::MODE_MAINT2, 11'h000});
    chk(w & C_MC, 16'h0000, "park clears");
    // A parked device serves no command, so a legal write request stays pending.
    hcp_host_model_inst.wr_word(hcp_pkg::CSR_FIRST_OFF, 2'b10, C_WR);
    repeat (4) @(posedge mclk);
    hcp_host_model_inst.rd_word(hcp_pkg::CSR_FIRST_OFF, w);
    chk(w, C_WR, "parked ignores");
    cmd(C_MC);
    chk(w, 16'h0000, "mode cleared");
    st_seen <= 1'b0;
    cmd(C_RUN | C_MC);
    chk(w, 16'h0000, "test and run status");
    chk({14'h0000, st_seen, app_run}, 16'h0003, "tested then ran");
    complete_run();
  end
endmodule : host_csr_firmware_command_port_tb
`default_nettype wire
